// file: pkg/lsm_defs.vh
// Register offsets, field positions, reset values and widths of the line status monitor.
// Included by the monitor module; holds definitions only.
`ifndef LSM_DEFS_VH
`define LSM_DEFS_VH

`define LSM_ADDR_W 11
`define LSM_CH_LSB 8
`define LSM_OFS_W 8

`define LSM_OFS_EDGE_SEL 8'h35
`define LSM_OFS_STATUS 8'h36
`define LSM_OFS_ATTEN 8'h37
`define LSM_OFS_TX_JITTER 8'h38
`define LSM_OFS_RX_JITTER 8'h39
`define LSM_OFS_IRQ_STATUS 8'h3A
`define LSM_OFS_IRQ_ENABLE 8'h3C
`define LSM_OFS_JIT_MODE 8'h3D

`define LSM_BIT_LOSS 0
`define LSM_BIT_ALARM 1
`define LSM_BIT_FAULT 2
`define LSM_BIT_TX_PEAK 0
`define LSM_BIT_RX_PEAK 1

`define LSM_EV_W 3
`define LSM_ATTEN_W 5
`define LSM_JIT_W 7

`define LSM_RST_EV 3'h0
`define LSM_RST_ATTEN 5'h00
`define LSM_RST_JIT 7'h00
`define LSM_RST_MODE 2'h0
`define LSM_RST_DATA 8'h00

`endif

// file: src/lsm_line_status_monitor.v
// Real-time line status, attenuation and jitter registers for eight line channels.
// Assumes detector inputs synchronous to sys_clk_in and a single-cycle strobe register port.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "lsm_defs.vh"

module lsm_line_status_monitor #(
   parameter CHANNELS = 8
) (
   // Clock and reset.
   input wire sys_clk_in,
   input wire rst_b_in,
   // Register port.
   input wire [`LSM_ADDR_W-1:0] addr_in,
   input wire [7:0] wr_data_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rd_data_out,
   // Detector inputs, one slice per channel.
   input wire [CHANNELS-1:0] driver_fault_in,
   input wire [CHANNELS-1:0] alarm_signal_in,
   input wire [CHANNELS-1:0] signal_loss_in,
   input wire [CHANNELS*`LSM_ATTEN_W-1:0] line_atten_code_in,
   input wire [CHANNELS*`LSM_JIT_W-1:0] tx_jitter_in,
   input wire [CHANNELS*`LSM_JIT_W-1:0] rx_jitter_in,
   // Interrupt.
   output reg irq_out
);

   wire [7:0] ofs = addr_in[`LSM_OFS_W-1:0];
   wire [2:0] ch_sel = addr_in[`LSM_ADDR_W-1:`LSM_CH_LSB];
   wire [7:0] ch_rd [0:CHANNELS-1];
   wire [CHANNELS-1:0] ch_irq;

   genvar c;
   genvar p;
   generate
      for (c = 0; c < CHANNELS; c = c + 1) begin : g_ch
         localparam [2:0] CH_ID = c;
         wire hit = (ch_sel == CH_ID);
         wire wr_ch = wr_in && hit;
         wire rd_ch = rd_in && hit;
         reg [`LSM_EV_W-1:0] flag;
         reg [`LSM_EV_W-1:0] flag_prev;
         reg [`LSM_EV_W-1:0] irq_status;
         reg [`LSM_EV_W-1:0] irq_enable;
         reg [`LSM_EV_W-1:0] edge_sel;
         reg [1:0] jit_mode;
         reg [`LSM_ATTEN_W-1:0] atten;
         wire [`LSM_JIT_W-1:0] jit_shown [0:1];
         wire [`LSM_EV_W-1:0] ev_rise = flag & ~flag_prev;
         wire [`LSM_EV_W-1:0] ev_any = flag ^ flag_prev;
         wire [`LSM_EV_W-1:0] ev = (edge_sel & ev_any) | (~edge_sel & ev_rise);
         wire [`LSM_EV_W-1:0] w1c = (wr_ch && ofs == `LSM_OFS_IRQ_STATUS) ?
            wr_data_in[`LSM_EV_W-1:0] : `LSM_RST_EV;
         wire [`LSM_EV_W-1:0] next_irq_status = (irq_status & ~w1c) | ev;

         always @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               flag <= `LSM_RST_EV;
               flag_prev <= `LSM_RST_EV;
               irq_status <= `LSM_RST_EV;
               irq_enable <= `LSM_RST_EV;
               edge_sel <= `LSM_RST_EV;
               jit_mode <= `LSM_RST_MODE;
               atten <= `LSM_RST_ATTEN;
            end else begin
               flag[`LSM_BIT_FAULT] <= driver_fault_in[c];
               flag[`LSM_BIT_ALARM] <= alarm_signal_in[c];
               flag[`LSM_BIT_LOSS] <= signal_loss_in[c];
               flag_prev <= flag;
               irq_status <= next_irq_status;
               atten <= line_atten_code_in[c*`LSM_ATTEN_W +: `LSM_ATTEN_W];
               if (wr_ch && ofs == `LSM_OFS_IRQ_ENABLE) begin
                  irq_enable <= wr_data_in[`LSM_EV_W-1:0];
               end
               if (wr_ch && ofs == `LSM_OFS_EDGE_SEL) begin
                  edge_sel <= wr_data_in[`LSM_EV_W-1:0];
               end
               if (wr_ch && ofs == `LSM_OFS_JIT_MODE) begin
                  jit_mode <= wr_data_in[1:0];
               end
            end
         end

         for (p = 0; p < 2; p = p + 1) begin : g_path
            wire [`LSM_JIT_W-1:0] src;
            if (p == 0) begin : g_tx
               assign src = tx_jitter_in[c*`LSM_JIT_W +: `LSM_JIT_W];
            end else begin : g_rx
               assign src = rx_jitter_in[c*`LSM_JIT_W +: `LSM_JIT_W];
            end
            localparam [7:0] OFS_J = (p == 0) ? `LSM_OFS_TX_JITTER : `LSM_OFS_RX_JITTER;
            wire rd_clr = rd_ch && (ofs == OFS_J);
            reg [`LSM_JIT_W-1:0] cur;
            reg [`LSM_JIT_W-1:0] hi;
            reg [`LSM_JIT_W-1:0] lo;
            always @(posedge sys_clk_in or negedge rst_b_in) begin
               if (!rst_b_in) begin
                  cur <= `LSM_RST_JIT;
                  hi <= `LSM_RST_JIT;
                  lo <= `LSM_RST_JIT;
               end else begin
                  cur <= src;
                  if (rd_clr) begin
                     hi <= src;
                     lo <= src;
                  end else begin
                     if (src > hi) begin
                        hi <= src;
                     end
                     if (src < lo) begin
                        lo <= src;
                     end
                  end
               end
            end
            assign jit_shown[p] = jit_mode[p] ? (hi - lo) : cur;
         end

         assign ch_irq[c] = |(irq_status & irq_enable);
         assign ch_rd[c] =
            (ofs == `LSM_OFS_STATUS) ? {5'h0, flag} :
            (ofs == `LSM_OFS_ATTEN) ? {3'h0, atten} :
            (ofs == `LSM_OFS_TX_JITTER) ? {1'b0, jit_shown[0]} :
            (ofs == `LSM_OFS_RX_JITTER) ? {1'b0, jit_shown[1]} :
            (ofs == `LSM_OFS_EDGE_SEL) ? {5'h0, edge_sel} :
            (ofs == `LSM_OFS_IRQ_STATUS) ? {5'h0, irq_status} :
            (ofs == `LSM_OFS_IRQ_ENABLE) ? {5'h0, irq_enable} :
            (ofs == `LSM_OFS_JIT_MODE) ? {6'h00, jit_mode} : `LSM_RST_DATA;
      end
   endgenerate

   wire [7:0] next_rd_data = (rd_in && ch_sel < CHANNELS) ? ch_rd[ch_sel] : `LSM_RST_DATA;

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out <= `LSM_RST_DATA;
         irq_out <= 1'b0;
      end else begin
         rd_data_out <= next_rd_data;
         irq_out <= |ch_irq;
      end
   end

endmodule // lsm_line_status_monitor

// file: testbench/lsm_checker_assertions.sv
// Assertions on the monitor ports, judged on channel 0 reads, jitter reads of any channel, idle cycles and irq falls.
// Bound into the monitor; sees only its ports.
`timescale 1ns/1ps
module lsm_checker #(parameter CHANNELS = 8) (
   // Clock, reset, register port and interrupt.
   input wire sys_clk_in, input wire rst_b_in, input wire [10:0] addr_in, input wire wr_in,
   input wire rd_in, input wire [7:0] rd_data_out, input wire irq_out,
   // Detector inputs.
   input wire [CHANNELS-1:0] driver_fault_in, alarm_signal_in, signal_loss_in,
   input wire [CHANNELS*5-1:0] line_atten_code_in);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_loss_flag: assert property ($past(rd_in && addr_in == 11'h036) |->
      rd_data_out[0] == $past(signal_loss_in[0], 2)) else $error("loss flag wrong");
   a_alarm_flag: assert property ($past(rd_in && addr_in == 11'h036) |->
      rd_data_out[1] == $past(alarm_signal_in[0], 2)) else $error("alarm flag wrong");
   a_fault_flag: assert property ($past(rd_in && addr_in == 11'h036) |->
      rd_data_out[2] == $past(driver_fault_in[0], 2)) else $error("fault flag wrong");
   a_atten_code: assert property ($past(rd_in && addr_in == 11'h037) |->
      rd_data_out == {3'h0, $past(line_atten_code_in[4:0], 2)}) else $error("atten wrong");
   a_jitter_reserved: assert property ($past(rd_in && addr_in[7:1] == 7'h1C) |->
      !rd_data_out[7]) else $error("jitter bit 7 set");
   a_unmapped_zero: assert property ($past(rd_in && addr_in == 11'h040) |->
      rd_data_out == 8'h00) else $error("unmapped read not zero");
   a_idle_data_zero: assert property (!$past(rd_in) |->
      rd_data_out == 8'h00) else $error("read data outside read cycle");
   a_irq_fall_cause: assert property ($fell(irq_out) |->
      $past(wr_in, 2)) else $error("irq fell without a write");
   cover property ($rose(irq_out));
   cover property (rd_in && addr_in == 11'h03A);
   cover property (rd_in && addr_in == 11'h039);
endmodule // lsm_checker
bind lsm_line_status_monitor lsm_checker #(.CHANNELS(CHANNELS)) u_chk (.sys_clk_in, .rst_b_in,
   .addr_in, .wr_in, .rd_in, .rd_data_out, .irq_out, .driver_fault_in, .alarm_signal_in,
   .signal_loss_in, .line_atten_code_in);

// file: testbench/test_line_status_monitor.sv
// Self-checking bench of the line status monitor through its register port.
// Assumes the monitor, its header and the checker are compiled beforehand.
`timescale 1ns/1ps
`define CK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module test_line_status_monitor;
   reg sys_clk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0;
   reg [10:0] addr_in = 0;
   reg [7:0] wr_data_in = 0;
   reg [23:0] ev = 0;
   reg [39:0] line_atten_code_in = 0;
   reg [6:0] jv = 0;
   wire [7:0] rd_data_out;
   wire irq_out;
   int bad_count = 0, num_checks = 0;
   lsm_line_status_monitor dut (.sys_clk_in, .rst_b_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
      .rd_data_out, .driver_fault_in(ev[23:16]), .alarm_signal_in(ev[15:8]),
      .signal_loss_in(ev[7:0]), .line_atten_code_in, .tx_jitter_in({49'h0, jv}),
      .rx_jitter_in({49'h0, jv}), .irq_out);
   initial begin
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   task cy(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task wr(input [10:0] a, input [7:0] v);
      @(posedge sys_clk_in);
      addr_in <= a;
      wr_data_in <= v;
      wr_in <= 1;
      @(posedge sys_clk_in);
      wr_in <= 0;
   endtask
   task rd(input [10:0] a);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1;
      @(posedge sys_clk_in);
      rd_in <= 0;
   endtask
   task rc(input [10:0] a, input [7:0] e);
      rd(a);
      #1 `CK("rd_data_out", e, rd_data_out)
   endtask
   task t_event(input int b);
      @(posedge sys_clk_in);
      ev[8*b] <= 1;
      cy(3);
      rc(11'h036, 8'h01 << b);
      rc(11'h03A, 8'h01 << b);
      `CK("irq_out", 1'b1, irq_out)
      wr(11'h03A, 8'h01 << b);
      ev[8*b] <= 0;
      cy(4);
      rc(11'h03A, 8'h00);
      `CK("irq_out", 1'b0, irq_out)
      wr(11'h035, 8'h01 << b);
      ev[8*b] <= 1;
      cy(4);
      wr(11'h03A, 8'h01 << b);
      ev[8*b] <= 0;
      cy(4);
      rc(11'h03A, 8'h01 << b);
      wr(11'h03A, 8'h01 << b);
      wr(11'h035, 8'h00);
   endtask
   task t_jit(input [10:0] a, input [7:0] m);
      jv <= 7'h55;
      cy(2);
      rc(a, 8'h55);
      wr(11'h03D, m);
      jv <= 7'h20;
      cy(2);
      rd(a);
      jv <= 7'h10;
      @(posedge sys_clk_in);
      jv <= 7'h40;
      @(posedge sys_clk_in);
      jv <= 7'h20;
      cy(2);
      rc(a, 8'h30);
      rc(a, 8'h00);
      wr(11'h03D, 8'h00);
   endtask
   task results;
      $display("checks %0d bad %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      cy(5);
      rst_b_in <= 1;
      rc(11'h036, 8'h00);
      wr(11'h036, 8'hFF);
      rc(11'h036, 8'h00);
      rc(11'h040, 8'h00);
      wr(11'h03C, 8'h07);
      for (int b = 0; b < 3; b++) t_event(b);
      line_atten_code_in <= {30'h0, 5'h15, 5'h16};
      ev[1] <= 1;
      cy(3);
      rc(11'h136, 8'h01);
      rc(11'h037, 8'h16);
      rc(11'h137, 8'h15);
      t_jit(11'h038, 8'h01);
      t_jit(11'h039, 8'h02);
      results;
   end
   initial begin
      #20000;
      bad_count++;
      results;
   end
endmodule // test_line_status_monitor
